// ### rtl/residual_overvoltage_timer_trip.sv
// Definite-time residual overvoltage start and trip logic.
// Assumes RMS and settings synchronous to clock_i, in percent and ms.
`timescale 1ns/1ps
`default_nettype none
`include "rovt_defs.svh"

// Overview of operation
// R1: Operation Off (default On) keeps start and trip outputs low.
// R2: Start when residual RMS exceeds start level, 2..60 percent, default 30.
// R3: Delay setting 0..60000 ms, default 100, independent of overvoltage size.
// R4: Start status stays high while the started condition holds.
// R5: Count elapsed ms once started; trip when count reaches the setting.
// R6: Start-only option, default false, passes start and suppresses general trip.
// R7: Blocking input from user logic disables both start and trip.
// R8: General start follows start; general trip follows gated trip.
// R9: Outputs follow input within one cycle, well inside timing limits.
// R10: Voltage at or below level clears start and zeroes the counter.
// R11: Counter advances on 1 ms tick; reset clears counter and outputs.
module residual_overvoltage_timer_trip
  import rovt_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES,
  parameter int unsigned RMS_W       = 8
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             srst_i,
  // Measurement and user blocking
  input  wire logic [RMS_W-1:0] residual_voltage_rms_i,
  input  wire logic             block_input_i,
  // Settings
  input  wire logic             operation_select_i,
  input  wire logic [7:0]       start_voltage_level_i,
  input  wire logic [15:0]      trip_delay_ms_i,
  input  wire logic             start_only_select_i,
  // Status
  output logic                  start_flag_o,
  output logic                  trip_flag_o,
  output logic                  general_start_out_o,
  output logic                  general_trip_out_o,
  output logic [15:0]           elapsed_ms_o
);
  // ----------------------------------------
  // Setting conditioning
  // ----------------------------------------
  logic [7:0]  level_eff;
  logic [15:0] delay_eff;
  logic        enabled;
  logic        over_level;
  tick_if      tick_bus ();

  // Out-of-range settings are clamped rather than trusted
  always_comb begin
    if (start_voltage_level_i < `LEVEL_MIN_PCT) begin
      level_eff = `LEVEL_MIN_PCT;
    end else if (start_voltage_level_i > `LEVEL_MAX_PCT) begin
      level_eff = `LEVEL_MAX_PCT;
    end else begin
      level_eff = start_voltage_level_i;
    end
  end

  assign delay_eff = (trip_delay_ms_i > `DELAY_MAX_MS) ? `DELAY_MAX_MS
                                                       : trip_delay_ms_i; // R3
  assign enabled    = (oper_t'(operation_select_i) == OPER_ON) && !block_input_i; // R1 R7
  assign over_level = {8'h00, residual_voltage_rms_i} > {8'h00, level_eff}; // R2

  // ----------------------------------------
  // Millisecond timebase
  // ----------------------------------------
  ms_tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .tick_io (tick_bus.source)
  );

  // ----------------------------------------
  // Definite-time state machine
  // ----------------------------------------
  timer_state_t state;
  timer_state_t next_state;
  logic [15:0]  count;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (enabled && over_level) begin
          next_state = (delay_eff == 16'h0000) ? ST_TRIPPED : ST_TIMING; // R5
        end
      end
      ST_TIMING: begin
        if (!enabled || !over_level) begin
          next_state = ST_IDLE; // R10
        end else if (tick_bus.tick && count + 16'h0001 >= delay_eff) begin
          next_state = ST_TRIPPED; // R5
        end else if (count >= delay_eff) begin
          next_state = ST_TRIPPED; // R5
        end
      end
      ST_TRIPPED: begin
        if (!enabled || !over_level) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state <= ST_IDLE; // R11
    end else begin
      state <= next_state;
    end
  end

  // Counter restarts from zero on each new start; the free-running tick can make the first ms partial
  always_ff @(posedge clock_i) begin
    if (srst_i || next_state == ST_IDLE || state == ST_IDLE) begin
      count <= 16'h0000; // R10 R11
    end else if (state == ST_TIMING && tick_bus.tick) begin
      count <= count + 16'h0001; // R11
    end
  end

  // ----------------------------------------
  // Decision logic
  // ----------------------------------------
  // Outputs are combinational from state and gating: drop-out is immediate
  assign start_flag_o        = (state != ST_IDLE) && enabled && over_level; // R4 R9
  assign trip_flag_o         = (state == ST_TRIPPED) && enabled && over_level; // R5
  assign general_start_out_o = start_flag_o; // R8
  assign general_trip_out_o  = trip_flag_o && !start_only_select_i; // R6 R8
  assign elapsed_ms_o        = count;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_off_quiet: assert property (@(posedge clock_i) disable iff (srst_i) // R1
    !operation_select_i |-> !general_start_out_o && !general_trip_out_o)
    else $error("outputs active while operation is off");

  chk_block_quiet: assert property (@(posedge clock_i) disable iff (srst_i) // R7
    block_input_i |-> !start_flag_o && !trip_flag_o)
    else $error("outputs active while blocked");

  chk_start_cause: assert property (@(posedge clock_i) disable iff (srst_i) // R2
    start_flag_o |-> residual_voltage_rms_i > level_eff)
    else $error("start without overvoltage");

  // The reset cycle forces idle, so its history must not count as a start
  chk_start_follow: assert property (@(posedge clock_i) disable iff (srst_i) // R4
    !$past(srst_i) && enabled && over_level && $past(enabled && over_level) |-> start_flag_o)
    else $error("start missing during sustained overvoltage");

  chk_trip_gated: assert property (@(posedge clock_i) disable iff (srst_i) // R6
    start_only_select_i |-> !general_trip_out_o)
    else $error("trip passed in start-only mode");

  chk_gen_start: assert property (@(posedge clock_i) disable iff (srst_i) // R8
    general_start_out_o == start_flag_o)
    else $error("general start differs from start");

  chk_trip_needs_start: assert property (@(posedge clock_i) disable iff (srst_i) // R5
    trip_flag_o |-> (start_flag_o && count >= delay_eff - 16'h0001)
      || delay_eff == 16'h0000
      || (state == ST_TRIPPED && $past(state) == ST_TRIPPED))
    else $error("trip before delay");

  chk_count_clear: assert property (@(posedge clock_i) disable iff (srst_i) // R10
    !over_level |=> count == 16'h0000)
    else $error("counter not cleared on drop-out");

  chk_drop_fast: assert property (@(posedge clock_i) disable iff (srst_i) // R9
    !over_level |-> !start_flag_o && !trip_flag_o)
    else $error("outputs slow to drop");

  chk_reset_clear: assert property (@(posedge clock_i) // R11
    srst_i |=> count == 16'h0000 && state == ST_IDLE)
    else $error("reset did not clear timer");

  chk_trip_at_count: assert property (@(posedge clock_i) disable iff (srst_i) // R5
    $rose(trip_flag_o) |-> count >= delay_eff)
    else $error("trip before count reached delay");

  chk_gen_trip: assert property (@(posedge clock_i) disable iff (srst_i) // R8
    general_trip_out_o |-> trip_flag_o && !start_only_select_i)
    else $error("general trip without gated trip");

  chk_start_only_pass: assert property (@(posedge clock_i) disable iff (srst_i) // R6
    start_only_select_i && start_flag_o |-> general_start_out_o)
    else $error("start suppressed in start-only mode");

  chk_level_range: assert property (@(posedge clock_i) disable iff (srst_i) // R2
    level_eff >= `LEVEL_MIN_PCT && level_eff <= `LEVEL_MAX_PCT)
    else $error("start level outside its range");

  // Count never passes the ceiling, even when the delay is lowered mid-run
  chk_delay_range: assert property (@(posedge clock_i) disable iff (srst_i) // R3
    delay_eff <= `DELAY_MAX_MS && count <= `DELAY_MAX_MS)
    else $error("delay or count above its ceiling");

  chk_tick_only: assert property (@(posedge clock_i) disable iff (srst_i) // R11
    $changed(count) && count != 16'h0000
      |-> $past(tick_bus.tick) && $past(state) == ST_TIMING)
    else $error("counter moved without a tick");

  chk_idle_count: assert property (@(posedge clock_i) disable iff (srst_i) // R10
    state == ST_IDLE |-> count == 16'h0000)
    else $error("counter nonzero while idle");

  // ----------------------------------------
  // Coverage
  // ----------------------------------------
  cov_start:   cover property (@(posedge clock_i) disable iff (srst_i) $rose(start_flag_o));
  cov_trip:    cover property (@(posedge clock_i) disable iff (srst_i) $rose(general_trip_out_o));
  cov_dropout: cover property (@(posedge clock_i) disable iff (srst_i)
    state == ST_TIMING ##1 state == ST_IDLE);
  cov_blocked: cover property (@(posedge clock_i) disable iff (srst_i)
    trip_flag_o ##1 block_input_i);
  cov_st_only: cover property (@(posedge clock_i) disable iff (srst_i)
    start_only_select_i && start_flag_o);
endmodule // residual_overvoltage_timer_trip
`default_nettype wire

// ### include/rovt_defs.svh
// Constants for the residual overvoltage timer trip block.
// Assumes a 50 MHz system clock.
`ifndef ROVT_DEFS_SVH
`define ROVT_DEFS_SVH

`define CLK_PERIOD_NS      20
`define MS_IN_NS           1000000
`define TICK_CYCLES        (`MS_IN_NS / `CLK_PERIOD_NS)
`define LEVEL_MIN_PCT      8'h02
`define LEVEL_MAX_PCT      8'h3c
`define LEVEL_RST_PCT      8'h1e
`define DELAY_MAX_MS       16'hea60
`define DELAY_RST_MS       16'h0064

`endif

// ### include/rovt_pkg.sv
// Types shared by the residual overvoltage timer trip files.
// Assumes nothing of its surroundings.
`default_nettype none
package rovt_pkg;
  typedef enum logic {
    OPER_OFF,
    OPER_ON
  } oper_t;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_TIMING,
    ST_TRIPPED
  } timer_state_t;
endpackage
`default_nettype wire

// ### include/tick_if.sv
// Millisecond tick carrier between the tick source and the timer.
// Assumes both ends share clock_i.
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
  logic tick;
  modport source (output tick);
  modport sink   (input  tick);
endinterface
`default_nettype wire

// ### rtl/ms_tick_gen.sv
// Free-running millisecond tick generator.
// Assumes synchronous active-high reset on clock_i.
`timescale 1ns/1ps
`default_nettype none
`include "rovt_defs.svh"
module ms_tick_gen #(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic srst_i,
  // Tick out
  tick_if.source    tick_io
);
  localparam int unsigned CW = $clog2(TICK_CYCLES + 1);
  logic [CW-1:0] count;

  always_ff @(posedge clock_i) begin
    if (srst_i || count == CW'(TICK_CYCLES - 1)) begin
      count <= '0;
    end else begin
      count <= count + CW'(1);
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      tick_io.tick <= 1'b0;
    end else begin
      tick_io.tick <= (count == CW'(TICK_CYCLES - 1));
    end
  end
endmodule // ms_tick_gen
`default_nettype wire

// ### tb/meas_model.sv
// Residual voltage measurement stage and user blocking source.
// Assumes the bench changes its requests at the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module meas_model (
  // Requests from the bench
  input  wire logic [7:0] set_rms_i,
  input  wire logic       set_blk_i,
  // Toward the block
  output logic      [7:0] rms_o,
  output logic            blk_o
);
  // Already settled RMS; filter ripple is not modelled
  assign rms_o = set_rms_i;
  assign blk_o = set_blk_i;
endmodule // meas_model
`default_nettype wire

// ### tb/residual_overvoltage_timer_trip_test.sv
// Self-checking bench for the residual overvoltage timer trip block.
// Assumes the include folder is on the search path.
`timescale 1ns/1ps
`default_nettype none
`define CHK_EQ(a, b, m) begin samples_checked++; if ((a) !== (b)) begin \
  bad_count++; $display("CHECK FAILED %0t %s", $time, m); end end
module residual_overvoltage_timer_trip_test;
  // Short tick keeps millisecond counts quick
  localparam int T = 4;
  logic        clock_i = 1'b0;
  logic        srst_i  = 1'b1;
  logic [7:0]  set_rms = 8'h00;
  logic [7:0]  lvl     = 8'h1e;
  logic [7:0]  rms;
  logic        set_blk = 1'b0;
  logic        oper    = 1'b1;
  logic        so      = 1'b0;
  logic        blk;
  logic [15:0] dly     = 16'h0003;
  logic [15:0] el;
  logic        st, tr, gs, gt;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          n;

  meas_model m (.set_rms_i(set_rms), .set_blk_i(set_blk), .rms_o(rms), .blk_o(blk));
  residual_overvoltage_timer_trip #(.TICK_CYCLES(T)) uut (
    .clock_i(clock_i), .srst_i(srst_i), .residual_voltage_rms_i(rms),
    .block_input_i(blk), .operation_select_i(oper), .start_voltage_level_i(lvl),
    .trip_delay_ms_i(dly), .start_only_select_i(so), .start_flag_o(st),
    .trip_flag_o(tr), .general_start_out_o(gs), .general_trip_out_o(gt),
    .elapsed_ms_o(el));

  always #10 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      end_sim;
    end
  end

  // ----
  // Stimulus
  // ----
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic drive(input logic [7:0] r, input logic b, o, s);
    @(negedge clock_i);
    set_rms = r;
    set_blk = b;
    oper = o;
    so = s;
    #1;
  endtask

  task automatic wait_trip(output int k);
    k = 0;
    while (tr !== 1'b1 && k < 40) begin
      @(negedge clock_i);
      k++;
    end
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    repeat (10) @(negedge clock_i);
    srst_i = 1'b0;
    `CHK_EQ({st, tr, gs, gt, el}, 20'h0, "outputs after reset")
  endtask

  // Same trip time for a small and a large overvoltage
  task automatic t_level;
    logic [7:0] over [2] = '{8'h1f, 8'hc8};
    drive(8'h1e, 1'b0, 1'b1, 1'b0);
    repeat (3) @(negedge clock_i);
    `CHK_EQ(st, 1'b0, "start at level")
    foreach (over[i]) begin
      drive(over[i], 1'b0, 1'b1, 1'b0);
      @(negedge clock_i);
      `CHK_EQ({st, gs}, 2'b11, "start")
      wait_trip(n);
      `CHK_EQ(n >= (dly - 1) * T && n <= dly * T + 1, 1'b1, "trip time")
      `CHK_EQ({tr, gt}, 2'b11, "trip")
      `CHK_EQ(el, dly, "count at trip")
      drive(8'h1e, 1'b0, 1'b1, 1'b0);
      `CHK_EQ({st, tr, gs, gt}, 4'h0, "drop")
      @(negedge clock_i);
      `CHK_EQ(el, 16'h0, "count cleared")
    end
  endtask

  task automatic t_gate;
    dly = 16'h0000;
    drive(8'h3c, 1'b0, 1'b1, 1'b1);
    repeat (2) @(negedge clock_i);
    `CHK_EQ({st, tr, gt}, 3'b110, "start only")
    drive(8'h3c, 1'b1, 1'b1, 1'b1);
    `CHK_EQ({st, tr, gs}, 3'b0, "blocked")
    drive(8'h3c, 1'b0, 1'b0, 1'b0);
    repeat (3) @(negedge clock_i);
    `CHK_EQ({st, tr, gs, gt}, 4'h0, "off")
    drive(8'h3c, 1'b0, 1'b1, 1'b0);
    repeat (2) @(negedge clock_i);
    `CHK_EQ({gs, gt}, 2'b11, "zero delay")
    srst_i = 1'b1;
    @(negedge clock_i);
    `CHK_EQ({st, tr, el}, 18'h0, "mid-run reset")
    srst_i = 1'b0;
    lvl = 8'h00;
    drive(8'h02, 1'b0, 1'b1, 1'b0);
    repeat (2) @(negedge clock_i);
    `CHK_EQ(st, 1'b0, "clamped level")
    drive(8'h03, 1'b0, 1'b1, 1'b0);
    @(negedge clock_i);
    `CHK_EQ(st, 1'b1, "above clamped level")
    lvl = 8'hff;
    drive(8'h3c, 1'b0, 1'b1, 1'b0);
    @(negedge clock_i);
    `CHK_EQ(st, 1'b0, "at clamped top level")
    drive(8'h3d, 1'b0, 1'b1, 1'b0);
    @(negedge clock_i);
    `CHK_EQ(st, 1'b1, "above clamped top level")
  endtask

  initial begin
    t_reset;
    t_level;
    t_gate;
    end_sim;
  end
endmodule // residual_overvoltage_timer_trip_test
`default_nettype wire
